// File: dv/velocity_loop_filter_chain_bench.sv
`timescale 1ns/1ps
module velocity_loop_filter_chain_bench;
    import vlf_pkg::*;
    localparam int SC = 8;
    logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, drive_enable, irq;
    logic        [31:0] haddr, hwdata, hrdata, x;
    logic        [1:0]  htrans;
    logic        [2:0]  hsize;
    logic signed [15:0] torque_cmd_in, integ_sum_in, speed_fb_in, current_act_in;
    logic signed [15:0] current_tgt_in, torque_out, integ_out, speed_fb_out;
    int                 n_fail = 0;
    int                 total_checks = 0;

    vlf_filter_chain #(.SAMPLE_CYCLES_P(SC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .drive_enable(drive_enable), .torque_cmd_in(torque_cmd_in),
        .integ_sum_in(integ_sum_in), .speed_fb_in(speed_fb_in),
        .current_act_in(current_act_in), .current_tgt_in(current_tgt_in),
        .torque_out(torque_out), .integ_out(integ_out), .speed_fb_out(speed_fb_out), .irq(irq));
    vlf_partner #(.HALF(SC)) far (.hclk(hclk), .hresetn(hresetn),
        .current_act_in(current_act_in), .current_tgt_in(current_tgt_in),
        .speed_fb_in(speed_fb_in));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
    endtask : wait_ready

    // address phase held until ready, then data phase held until ready
    task automatic bus(input logic [29:0] idx, input logic wr_en, input logic [31:0] wd);
        haddr  <= {idx, 2'b00};
        hwrite <= wr_en;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        x = hrdata;
    endtask : bus

    task automatic wr(input logic [29:0] idx, input logic [31:0] d);
        bus(idx, 1'b1, d);
    endtask : wr

    task automatic rd_chk(input logic [29:0] idx, input logic [31:0] e);
        bus(idx, 1'b0, 32'h0);
        check(x, e);
    endtask : rd_chk

    // start an analysis, poll until busy drops, then check both tuned notches
    task automatic run_fft(input logic [31:0] c, input logic [31:0] f0, input logic [31:0] f1);
        wr(IDX_NOTCH_CTRL, c);
        rd_chk(IDX_NOTCH_CTRL, c);
        for (int i = 0; i < 200; i++) begin
            repeat (100) @(posedge hclk);
            bus(IDX_NOTCH_CTRL, 1'b0, 32'h0);
            if (x[7] === 1'b0) break;
        end
        check(x, c & 32'h7f);
        if (x[7] !== 1'b0) tally_and_finish();
        rd_chk(IDX_NOTCH_ZERO, f0);
        rd_chk(IDX_NOTCH_ONE, f1);
        rd_chk(IDX_IRQ_STATUS, 32'h1);
    endtask : run_fft

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        hresetn = 1'b0; hsel = 1'b1; haddr = '0; htrans = '0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; drive_enable = 1'b0; torque_cmd_in = '0; integ_sum_in = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int i = 0; i < 4; i++) rd_chk(NOTCH_IDX[i], 32'h226);
        rd_chk(IDX_NOTCH_CTRL, 32'h0);
        rd_chk(IDX_FB_SETTING, 32'h7);
        rd_chk(IDX_SPEED_MODE, 32'h0);
        rd_chk(IDX_OUT_DIV, 32'h1);
        rd_chk(30'h0000010, 32'h0);
        check({31'h0, hresp}, 32'h0);
        wr(IDX_NOTCH_ZERO, 32'h63);
        rd_chk(IDX_NOTCH_ZERO, 32'h226);
        wr(IDX_NOTCH_THREE, 32'h7d0);
        rd_chk(IDX_NOTCH_THREE, 32'h7d0);
        wr(IDX_FB_SETTING, 32'h2e);
        rd_chk(IDX_FB_SETTING, 32'h7);
        wr(IDX_FB_SETTING, 32'h2d);
        rd_chk(IDX_FB_SETTING, 32'h2d);
        $display("test registers done");
        wr(IDX_SPEED_MODE, 32'h1);
        torque_cmd_in <= 16'sh0abc;
        repeat (4 * SC) @(posedge hclk);
        check({16'h0, torque_out}, 32'h0abc);
        check({16'h0, speed_fb_out}, 32'h04d2);
        wr(IDX_SPEED_MODE, 32'h4);
        repeat (2 * SC) @(posedge hclk);
        check(32'(speed_fb_out > 16'sh0400 && speed_fb_out <= 16'sh04d2), 32'h1);
        wr(IDX_OUT_DIV, 32'h64);
        torque_cmd_in <= 16'sh1abc;
        repeat (2 * SC) @(posedge hclk);
        check(32'(torque_out < 16'sh1abc && torque_out >= 16'sh0abc), 32'h1);
        $display("test torque path done");
        wr(IDX_INTEG_LIMIT, 32'h64);
        wr(IDX_IRQ_MASK, 32'h4);
        integ_sum_in <= 16'sh01f4;
        repeat (3) @(posedge hclk);
        check({16'h0, integ_out}, 32'h64);
        check({31'h0, irq}, 32'h1);
        integ_sum_in <= -16'sh01f4;
        repeat (3) @(posedge hclk);
        check({16'h0, integ_out}, 32'hff9c);
        integ_sum_in <= '0;
        repeat (3) @(posedge hclk);
        rd_chk(IDX_IRQ_STATUS, 32'h4);
        repeat (3) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        $display("test clamp done");
        wr(IDX_NOTCH_CTRL, 32'h80);
        rd_chk(IDX_NOTCH_CTRL, 32'h0);
        rd_chk(IDX_IRQ_STATUS, 32'h2);
        // the start is only issued with the drive enabled and settled
        drive_enable <= 1'b1;
        repeat (6) @(posedge hclk);
        // toggling actual current clamps high, still target and speed clamp low
        run_fft(32'h92, 32'h7d0, 32'h7d0);
        run_fft(32'ha0, 32'h64, 32'h64);
        run_fft(32'h80, 32'h7d0, 32'h7d0);
        $display("test analysis done");
        tally_and_finish();
    end
endmodule : velocity_loop_filter_chain_bench

// File: dv/vlf_partner.sv
`timescale 1ns/1ps
module vlf_partner #(
    parameter int HALF = 8
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    output logic signed [15:0] current_act_in,
    output logic signed [15:0] current_tgt_in,
    output logic signed [15:0] speed_fb_in
);
    int cnt;
    // one swing per sample period, so every sample is a sign change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt            <= 0;
            current_act_in <= 16'sh03e8;
        end else begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                current_act_in <= -current_act_in;
            end
        end
    end
    // target current and speed hold still: no crossings to count
    assign current_tgt_in = 16'sh012c;
    assign speed_fb_in    = 16'sh04d2;
endmodule : vlf_partner

// File: logic/vlf_filter_chain.sv
// Contract
// - torque command passes first-order low-pass, cutoff 1/(2*pi*Ts*N) per sample.
// - divisor one means torque filter off, command passes unfiltered.
// - feedback filter bandwidth is setting times twenty plus one hundred hertz.
// - velocity feedback mode selects first- or second-order feedback low-pass.
// - after reset the feedback path uses the second-order low-pass.
// - notch frequencies default 550, accept only 100 to 2000.
// - notch control bits 1:0 select which notch filters run.
// - control bit 4, or control bits 6:0 all zero, picks actual current, else target current, as analysis input.
// - control bit 5 adds actual speed to the analysis.
// - writing bit 7 starts analysis; bit 7 clears itself at completion.
// - analysis start is refused while the drive is disabled.
// - control zero disables notches; one enables only notch zero.
// - analysis completion writes measured frequencies into notches zero and one.
// - notches two and three are manual only, switched by notch control.
// - control value 128 starts analysis on actual current.
// - integrator output is clamped to the integral output limit.
// - feedback filter setting accepts 0 to 45, default 7.
`timescale 1ns/1ps
module vlf_filter_chain
    import vlf_pkg::*;
#(
    parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic      [31:0]        hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire logic               drive_enable,
    input  wire logic signed [15:0] torque_cmd_in,
    input  wire logic signed [15:0] integ_sum_in,
    input  wire logic signed [15:0] speed_fb_in,
    input  wire logic signed [15:0] current_act_in,
    input  wire logic signed [15:0] current_tgt_in,
    output logic signed [15:0]      torque_out,
    output logic signed [15:0]      integ_out,
    output logic signed [15:0]      speed_fb_out,
    output logic                    irq
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    function automatic logic reg_hit(logic [29:0] a, logic [29:0] idx);
        return a == idx;
    endfunction : reg_hit

    function automatic logic [16:0] hz_coef(logic [15:0] hz);
        return 17'(hz * COEF_PER_HZ);
    endfunction : hz_coef

    function automatic logic signed [17:0] qmul(logic signed [17:0] a, logic [16:0] k);
        logic signed [35:0] p;
        p = a * $signed({1'b0, k});
        return p[33:16];
    endfunction : qmul

    function automatic logic signed [15:0] sat16(logic signed [17:0] v);
        if (v[17:15] == {3{v[17]}}) return v[15:0];
        return {v[17], {15{~v[17]}}};
    endfunction : sat16

    function automatic logic [15:0] freq_est(logic [11:0] c);
        logic [23:0] f;
        f = (c * FREQ_MUL) >> FREQ_SH;
        if (f < 24'(NOTCH_MIN)) return NOTCH_MIN;
        if (f > 24'(NOTCH_MAX)) return NOTCH_MAX;
        return f[15:0];
    endfunction : freq_est

    // a bare start request (value 128) always analyses the actual current
    function automatic logic src_act(logic [6:0] c);
        return c[CTRL_SRC_ACT] || c == '0;
    endfunction : src_act

    // ---------------- bus slave ----------------
    logic        wr_pend_reg;
    logic [29:0] wr_idx_reg;
    logic [31:0] rd_val;
    logic        ahb_take;
    logic        status_rd;
    logic [15:0] notch_freq_reg [4];
    logic [6:0]  ctrl_reg;
    logic [5:0]  fb_setting_reg;
    logic [6:0]  speed_mode_reg;
    logic [15:0] out_div_reg;
    logic [15:0] limit_reg;
    logic [IRQ_W-1:0] status_reg;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] status_set;
    vlf_fft_state_t   fft_state;

    assign ahb_take  = hsel && hready && htrans[1];
    assign status_rd = ahb_take && !hwrite && reg_hit(haddr[31:2], IDX_IRQ_STATUS);

    always_comb begin
        rd_val = '0;
        for (int i = 0; i < 4; i++) begin
            if (reg_hit(haddr[31:2], NOTCH_IDX[i])) rd_val = 32'(notch_freq_reg[i]);
        end
        if (reg_hit(haddr[31:2], IDX_NOTCH_CTRL))
            rd_val = 32'({fft_state == FFT_RUN, ctrl_reg});
        if (reg_hit(haddr[31:2], IDX_FB_SETTING))  rd_val = 32'(fb_setting_reg);
        if (reg_hit(haddr[31:2], IDX_SPEED_MODE))  rd_val = 32'(speed_mode_reg);
        if (reg_hit(haddr[31:2], IDX_OUT_DIV))     rd_val = 32'(out_div_reg);
        if (reg_hit(haddr[31:2], IDX_INTEG_LIMIT)) rd_val = 32'(limit_reg);
        if (reg_hit(haddr[31:2], IDX_IRQ_STATUS))  rd_val = 32'(status_reg);
        if (reg_hit(haddr[31:2], IDX_IRQ_MASK))    rd_val = 32'(mask_reg);
    end

    // zero wait states: data phase always completes in one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= '0;
            hrdata      <= '0;
            hreadyout   <= 1'b0;
            hresp       <= 1'b0;
        end else begin
            hreadyout   <= 1'b1;
            hresp       <= 1'b0;
            wr_pend_reg <= ahb_take && hwrite;
            if (ahb_take) wr_idx_reg <= haddr[31:2];
            if (ahb_take && !hwrite) hrdata <= rd_val;
        end
    end

    function automatic logic wr_to(logic [29:0] idx);
        return wr_pend_reg && reg_hit(wr_idx_reg, idx);
    endfunction : wr_to

    // ---------------- drive enable synchroniser ----------------
    logic en_s1_reg, en_s2_reg, en_s3_reg, drive_en_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_s1_reg    <= 1'b0;
            en_s2_reg    <= 1'b0;
            en_s3_reg    <= 1'b0;
            drive_en_reg <= 1'b0;
        end else begin
            en_s1_reg <= drive_enable;
            en_s2_reg <= en_s1_reg;
            en_s3_reg <= en_s2_reg;
            if (en_s2_reg == en_s3_reg) drive_en_reg <= en_s3_reg;
        end
    end

    // ---------------- sample tick ----------------
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_W'(SAMPLE_CYCLES_P - 1)) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg     <= 1'b0;
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_setting_reg <= FB_SET_RST;
            speed_mode_reg <= MODE_SECOND;
            out_div_reg    <= OUT_DIV_OFF;
            limit_reg      <= LIMIT_RST;
            mask_reg       <= '0;
            ctrl_reg       <= '0;
        end else begin
            // out-of-range feedback setting, divisor and limit writes are dropped, the old value stays
            if (wr_to(IDX_FB_SETTING) && hwdata[31:0] <= 32'(FB_SET_MAX))
                fb_setting_reg <= hwdata[5:0];
            if (wr_to(IDX_SPEED_MODE)) speed_mode_reg <= hwdata[6:0];
            if (wr_to(IDX_OUT_DIV) && hwdata[31:0] != '0 && hwdata[31:0] <= 32'(OUT_DIV_MAX))
                out_div_reg <= hwdata[15:0];
            if (wr_to(IDX_INTEG_LIMIT) && hwdata[31:0] <= 32'(LIMIT_MAX))
                limit_reg <= hwdata[15:0];
            if (wr_to(IDX_IRQ_MASK)) mask_reg <= hwdata[IRQ_W-1:0];
            if (wr_to(IDX_NOTCH_CTRL)) ctrl_reg <= hwdata[6:0];
        end
    end

    // ---------------- resonance analysis ----------------
    logic                 start_req;
    logic                 fft_done_reg;
    logic [FFT_WIN_W-1:0] win_reg;
    logic [10:0]          cross_cur_reg, cross_spd_reg;
    logic                 sign_cur_reg, sign_spd_reg;
    logic signed [15:0]   fft_src;
    logic [15:0]          est0, est1;

    assign start_req = wr_to(IDX_NOTCH_CTRL) && hwdata[CTRL_START];
    assign fft_src   = src_act(ctrl_reg) ? current_act_in : current_tgt_in;
    assign est0      = freq_est({cross_cur_reg, 1'b0} >> 1);
    // without speed data the second notch goes to the current's second harmonic
    assign est1      = ctrl_reg[CTRL_SPEED] ? freq_est({1'b0, cross_spd_reg})
                                            : freq_est({cross_cur_reg, 1'b0});

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fft_state     <= FFT_IDLE;
            fft_done_reg  <= 1'b0;
            win_reg       <= '0;
            cross_cur_reg <= '0;
            cross_spd_reg <= '0;
            sign_cur_reg  <= 1'b0;
            sign_spd_reg  <= 1'b0;
        end else begin
            fft_done_reg <= 1'b0;
            case (fft_state)
                FFT_IDLE: begin
                    if (start_req && drive_en_reg) begin
                        fft_state     <= FFT_RUN;
                        win_reg       <= '0;
                        cross_cur_reg <= '0;
                        cross_spd_reg <= '0;
                        sign_cur_reg  <= src_act(hwdata[6:0]) ? current_act_in[15]
                                                              : current_tgt_in[15];
                        sign_spd_reg  <= speed_fb_in[15];
                    end
                end
                FFT_RUN: begin
                    if (!drive_en_reg || (wr_to(IDX_NOTCH_CTRL) && !hwdata[CTRL_START])) begin
                        fft_state <= FFT_IDLE;
                    end else if (tick_reg) begin
                        sign_cur_reg <= fft_src[15];
                        sign_spd_reg <= speed_fb_in[15];
                        if (fft_src[15] != sign_cur_reg) cross_cur_reg <= cross_cur_reg + 1'b1;
                        if (speed_fb_in[15] != sign_spd_reg)
                            cross_spd_reg <= cross_spd_reg + 1'b1;
                        win_reg <= win_reg + 1'b1;
                        if (win_reg == FFT_WIN_END) begin
                            fft_state    <= FFT_IDLE;
                            fft_done_reg <= 1'b1;
                        end
                    end
                end
                default: fft_state <= FFT_IDLE;
            endcase
        end
    end

    // analysis results win over a bus write landing in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) notch_freq_reg[i] <= NOTCH_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_to(NOTCH_IDX[i]) && hwdata[31:0] >= 32'(NOTCH_MIN)
                    && hwdata[31:0] <= 32'(NOTCH_MAX))
                    notch_freq_reg[i] <= hwdata[15:0];
            end
            if (fft_done_reg) begin
                notch_freq_reg[0] <= est0;
                notch_freq_reg[1] <= est1;
            end
        end
    end

    // ---------------- integrator limit ----------------
    logic signed [16:0] lim_s;
    logic               clamp_hit;
    assign lim_s     = $signed({1'b0, limit_reg});
    assign clamp_hit = 17'(integ_sum_in) > lim_s || 17'(integ_sum_in) < -lim_s;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            integ_out <= '0;
        end else if (17'(integ_sum_in) > lim_s) begin
            integ_out <= 16'(lim_s);
        end else if (17'(integ_sum_in) < -lim_s) begin
            integ_out <= 16'(-lim_s);
        end else begin
            integ_out <= integ_sum_in;
        end
    end

    // ---------------- speed feedback low-pass ----------------
    logic signed [15:0] fb_s1_reg, fb_s2_reg, fb1_next, fb2_next;
    logic [16:0]        fb_coef;
    assign fb_coef  = hz_coef(FB_BASE_HZ + 16'(FB_STEP_HZ * fb_setting_reg));
    assign fb1_next = sat16(18'(fb_s1_reg) + qmul(18'(speed_fb_in) - 18'(fb_s1_reg), fb_coef));
    assign fb2_next = sat16(18'(fb_s2_reg) + qmul(18'(fb1_next) - 18'(fb_s2_reg), fb_coef));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_s1_reg    <= '0;
            fb_s2_reg    <= '0;
            speed_fb_out <= '0;
        end else if (tick_reg) begin
            fb_s1_reg <= fb1_next;
            fb_s2_reg <= fb2_next;
            case (speed_mode_reg)
                MODE_BYPASS: speed_fb_out <= speed_fb_in;
                MODE_FIRST:  speed_fb_out <= fb1_next;
                default:     speed_fb_out <= fb2_next;
            endcase
        end
    end

    // ---------------- torque filter ----------------
    logic signed [15:0] torque_lpf_reg;
    logic signed [16:0] torque_diff;
    assign torque_diff = 17'(torque_cmd_in) - 17'(torque_lpf_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            torque_lpf_reg <= '0;
        end else if (tick_reg) begin
            if (out_div_reg == OUT_DIV_OFF)
                torque_lpf_reg <= torque_cmd_in;
            else // step of 1/N per sample gives the 1/(2*pi*Ts*N) corner
                torque_lpf_reg <= torque_lpf_reg
                    + 16'(torque_diff / $signed({1'b0, out_div_reg}));
        end
    end

    // ---------------- notch cascade ----------------
    logic [2:0]         notch_cnt;
    logic signed [17:0] low_reg [4];
    logic signed [17:0] band_reg [4];
    logic signed [17:0] low_next [4];
    logic signed [17:0] band_next [4];
    logic signed [17:0] nv, nhi, nbn;
    logic [16:0]        nk;

    // 0: none, 1: notch zero, 2: notches zero and one, 3: all four
    always_comb begin
        case (ctrl_reg[CTRL_SEL_HI:CTRL_SEL_LO])
            2'h0:    notch_cnt = 3'h0;
            2'h1:    notch_cnt = 3'h1;
            2'h2:    notch_cnt = 3'h2;
            default: notch_cnt = 3'h4;
        endcase
    end

    always_comb begin
        nv  = 18'(torque_lpf_reg);
        nhi = '0;
        nbn = '0;
        nk  = '0;
        for (int i = 0; i < 4; i++) begin
            low_next[i]  = '0;
            band_next[i] = '0;
            if (3'(i) < notch_cnt) begin
                nk           = hz_coef(notch_freq_reg[i]);
                nhi          = nv - low_reg[i] - band_reg[i];
                nbn          = band_reg[i] + qmul(nhi, nk);
                band_next[i] = nbn;
                low_next[i]  = low_reg[i] + qmul(nbn, nk);
                nv           = nv - nbn;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                low_reg[i]  <= '0;
                band_reg[i] <= '0;
            end
            torque_out <= '0;
        end else if (tick_reg) begin
            for (int i = 0; i < 4; i++) begin
                low_reg[i]  <= low_next[i];
                band_reg[i] <= band_next[i];
            end
            torque_out <= sat16(nv);
        end
    end

    // ---------------- interrupts ----------------
    assign status_set = {clamp_hit, fft_state == FFT_IDLE && start_req && !drive_en_reg,
                         fft_done_reg};

    // a new event in the reading cycle survives the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_reg <= '0;
            irq        <= 1'b0;
        end else begin
            status_reg <= (status_rd ? '0 : status_reg) | status_set;
            irq        <= |(((status_rd ? '0 : status_reg) | status_set) & mask_reg);
        end
    end

    // ---------------- checks ----------------
    sequence s_start_req;
        fft_state == FFT_IDLE && start_req;
    endsequence
    sequence s_fft_end;
        fft_state == FFT_RUN ##1 fft_done_reg;
    endsequence

    chk_torque_bypass: assert property (
        tick_reg && out_div_reg == OUT_DIV_OFF |=> torque_lpf_reg == $past(torque_cmd_in))
        else $error("torque filter not bypassed at divisor one");
    chk_fb_first_order: assert property (
        tick_reg && speed_mode_reg == MODE_FIRST |=> speed_fb_out == fb_s1_reg)
        else $error("first order feedback not selected");
    chk_fb_default: assert property (
        $rose(hresetn) |-> speed_mode_reg == MODE_SECOND && fb_setting_reg == FB_SET_RST)
        else $error("feedback filter defaults wrong");
    chk_fb_range: assert property (fb_setting_reg <= FB_SET_MAX)
        else $error("feedback setting out of range");
    chk_notch_range: assert property (
        notch_freq_reg[0] >= NOTCH_MIN && notch_freq_reg[0] <= NOTCH_MAX
        && notch_freq_reg[3] >= NOTCH_MIN && notch_freq_reg[3] <= NOTCH_MAX)
        else $error("notch frequency out of range");
    chk_notch_off: assert property (
        tick_reg && notch_cnt == 3'h0 |=> torque_out == $past(torque_lpf_reg))
        else $error("notches not bypassed at control zero");
    chk_start_refused: assert property (
        s_start_req and !drive_en_reg |=> fft_state == FFT_IDLE && status_reg[IRQ_REFUSED])
        else $error("analysis started while disabled");
    chk_fft_complete: assert property (
        s_fft_end |=> fft_state == FFT_IDLE && notch_freq_reg[0] == $past(est0)
        && notch_freq_reg[1] == $past(est1) && status_reg[IRQ_DONE])
        else $error("analysis end did not update notches");
    chk_integ_clamp: assert property (
        ##1 17'(integ_out) <= $past(lim_s) && 17'(integ_out) >= -$past(lim_s))
        else $error("integrator output beyond limit");
    chk_tick_gap: assert property (tick_reg |=> !tick_reg)
        else $error("sample ticks back to back");
endmodule : vlf_filter_chain

// File: logic/vlf_pkg.sv
package vlf_pkg;
    // clock and sample timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SAMPLE_PERIOD_NS = 62500;
    localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W           = 13;

    // register word indices, byte address is four times the index
    localparam logic [29:0] IDX_NOTCH_ZERO  = 30'h060f903;
    localparam logic [29:0] IDX_NOTCH_ONE   = 30'h0250b01;
    localparam logic [29:0] IDX_NOTCH_TWO   = 30'h0250b02;
    localparam logic [29:0] IDX_NOTCH_THREE = 30'h0250b03;
    localparam logic [29:0] IDX_NOTCH_CTRL  = 30'h060f904;
    localparam logic [29:0] IDX_FB_SETTING  = 30'h060f905;
    localparam logic [29:0] IDX_SPEED_MODE  = 30'h060f906;
    localparam logic [29:0] IDX_INTEG_LIMIT = 30'h060f908;
    localparam logic [29:0] IDX_OUT_DIV     = 30'h060f915;
    localparam logic [29:0] IDX_IRQ_STATUS  = 30'h060f980;
    localparam logic [29:0] IDX_IRQ_MASK    = 30'h060f981;
    localparam logic [29:0] NOTCH_IDX [4]   = '{IDX_NOTCH_ZERO, IDX_NOTCH_ONE,
                                                IDX_NOTCH_TWO, IDX_NOTCH_THREE};

    // reset values and ranges
    localparam logic [15:0] NOTCH_RST     = 16'h0226;
    localparam logic [15:0] NOTCH_MIN     = 16'h0064;
    localparam logic [15:0] NOTCH_MAX     = 16'h07d0;
    localparam logic [5:0]  FB_SET_RST    = 6'h07;
    localparam logic [5:0]  FB_SET_MAX    = 6'h2d;
    localparam logic [15:0] FB_BASE_HZ    = 16'h0064;
    localparam logic [15:0] FB_STEP_HZ    = 16'h0014;
    localparam logic [6:0]  MODE_SECOND   = 7'h00;
    localparam logic [6:0]  MODE_BYPASS   = 7'h01;
    localparam logic [6:0]  MODE_FIRST    = 7'h04;
    localparam logic [15:0] OUT_DIV_OFF   = 16'h0001;
    localparam logic [15:0] OUT_DIV_MAX   = 16'h055a;
    localparam logic [15:0] LIMIT_RST     = 16'h7fff;
    localparam logic [16:0] LIMIT_MAX     = 17'h08000;

    // notch control fields
    localparam int CTRL_SEL_LO  = 0;
    localparam int CTRL_SEL_HI  = 1;
    localparam int CTRL_SRC_ACT = 4;
    localparam int CTRL_SPEED   = 5;
    localparam int CTRL_START   = 7;

    // interrupt status bits
    localparam int IRQ_W       = 3;
    localparam int IRQ_DONE    = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_CLAMP   = 2;

    // 2*pi*Ts*2^16 per hertz, rounded
    localparam logic [16:0] COEF_PER_HZ = 17'h0001a;

    // resonance estimate: crossings * 16 kHz / (2 * window) = crossings * 125 / 16
    localparam int          FFT_WIN_W  = 10;
    localparam logic [9:0]  FFT_WIN_END = 10'h3ff;
    localparam logic [11:0] FREQ_MUL   = 12'h07d;
    localparam int          FREQ_SH    = 4;

    typedef enum {FFT_IDLE, FFT_RUN} vlf_fft_state_t;
endpackage : vlf_pkg
